/* core/radio_cfg_pkg.sv */
package radio_cfg_pkg;

  // Register offsets on the control port
  localparam logic [9:0] RX_DELAY_OFFSET = 10'h109;
  localparam logic [9:0] TX_DELAY_OFFSET = 10'h10A;
  localparam logic [9:0] DELAY_EXT_OFFSET = 10'h10B;
  localparam logic [9:0] PKT_FORMAT_OFFSET = 10'h13E;
  localparam logic [9:0] CHAN_LOW_OFFSET = 10'h300;
  localparam logic [9:0] CHAN_MID_OFFSET = 10'h301;
  localparam logic [9:0] CHAN_HIGH_OFFSET = 10'h302;
  localparam logic [9:0] TX_MOD_OFFSET = 10'h306;
  localparam logic [9:0] POWER_OFFSET = 10'h30C;
  localparam logic [9:0] QUALITY_OFFSET = 10'h30D;
  localparam logic [9:0] PRAM_PAGE_OFFSET = 10'h313;
  localparam logic [9:0] TX_BASE_OFFSET = 10'h314;
  localparam logic [9:0] RX_BASE_OFFSET = 10'h315;
  localparam logic [9:0] WAKE_DIV_OFFSET = 10'h316;
  localparam logic [9:0] WAKE_SLEEP_OFFSET = 10'h317;
  localparam logic [9:0] RELOAD_HIGH_OFFSET = 10'h318;
  localparam logic [9:0] RELOAD_LOW_OFFSET = 10'h319;

  // Reset values
  localparam logic [7:0] RX_DELAY_RESET = 8'hC0;
  localparam logic [7:0] TX_DELAY_RESET = 8'hC0;
  localparam logic [7:0] DELAY_EXT_RESET = 8'h00;
  localparam logic [7:0] PKT_FORMAT_RESET = 8'h00;
  localparam logic [7:0] CHAN_LOW_RESET = 8'h80;
  localparam logic [7:0] CHAN_MID_RESET = 8'hA9;
  localparam logic [7:0] CHAN_HIGH_RESET = 8'h03;
  localparam logic [7:0] TX_MOD_RESET = 8'h01;
  localparam logic [7:0] READBACK_RESET = 8'h00;
  localparam logic [3:0] PRAM_PAGE_RESET = 4'h0;
  localparam logic [7:0] TX_BASE_RESET = 8'h80;
  localparam logic [7:0] RX_BASE_RESET = 8'h00;
  localparam logic [2:0] WAKE_DIV_RESET = 3'h0;
  localparam logic [3:0] SLEEP_CODE_RESET = 4'h0;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // Field positions
  localparam int PREEMP_BIT = 0;
  localparam int WAKE_ON_TIMEOUT_BIT = 0;
  localparam int SLEEP_CODE_LSB = 3;
  localparam int SLEEP_CODE_MSB = 6;
  localparam int WAKE_DIV_MSB = 2;
  localparam int PRAM_PAGE_MSB = 3;

  // Packet format codes
  localparam logic [7:0] FORMAT_PACKET = 8'h00;
  localparam logic [7:0] FORMAT_RX_SERIAL = 8'h02;
  localparam logic [7:0] FORMAT_TX_SERIAL = 8'h03;

  // Sleep retention codes
  localparam logic [3:0] SLEEP_KEEP_BACKUP_RAM = 4'h1;
  localparam logic [3:0] SLEEP_KEEP_CRYSTAL_OSC = 4'h4;
  localparam logic [3:0] SLEEP_KEEP_RAM_AND_CRYSTAL = 4'h5;
  localparam logic [3:0] SLEEP_KEEP_RAM_AND_RC_OSC = 4'hB;

  // Last count of the slow-clock divider, one per code 0..7
  localparam logic [15:0] DIV_LAST_0 = 16'h0000;
  localparam logic [15:0] DIV_LAST_1 = 16'h0003;
  localparam logic [15:0] DIV_LAST_2 = 16'h0007;
  localparam logic [15:0] DIV_LAST_3 = 16'h000F;
  localparam logic [15:0] DIV_LAST_4 = 16'h007F;
  localparam logic [15:0] DIV_LAST_5 = 16'h03FF;
  localparam logic [15:0] DIV_LAST_6 = 16'h1FFF;
  localparam logic [15:0] DIV_LAST_7 = 16'hFFFF;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BASE_STEP_NS = 1000;
  localparam int EXT_STEP_US = 4;
  localparam int CYCLES_PER_US = (BASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] US_LAST = 5'(CYCLES_PER_US - 1);
  localparam int EXT_SHIFT = $clog2(EXT_STEP_US);

  // Start delay sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_TX_WAIT = 3'b010,
    SEQ_RX_WAIT = 3'b100
  } seq_state_t;

endpackage

/* core/radio_config_register_bank.sv */
// Operation
// - Transmit command waits the transmit start delay, 1 us steps, reset 192.
// - Delay extension adds 4 us steps, reset 0, in receive and transmit.
// - Format 0 is packet mode, 2 receive serial port, 3 transmit serial port.
// - Channel word is 24 bits, frequency over 10 kHz, three byte registers.
// - Channel bytes reset to 128, 169 and 3.
// - Modulation bit 0 enables preemphasis, resets to 1.
// - Input power readback is signed 8-bit, read only, resets to 0.
// - Signal quality readback is 8-bit, read only, resets to 0.
// - Transmit buffer start address, 8 bits, resets to 128.
// - Receive buffer start address, 8 bits, resets to 0.
// - Wake divider codes 0..7 divide slow clock by 1,4,8,16,128,1024,8192,65536.
// - Divider is staged and takes effect only when sleep config is written.
// - Sleep codes: 1 backup RAM, 4 crystal, 5 both, 11 RAM with RC.
// - Sleep config bit 0 enables wake on timer timeout.
// - Reload written high byte first, applied on low byte write.
// - Receive command waits the receive start delay, reset 192.
`timescale 1ns/100ps
module radio_config_register_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Radio commands and start events
  input wire logic transmit_command,
  input wire logic receive_command,
  output logic transmit_state_enter,
  output logic receive_search_start,
  output logic start_delay_busy,
  // Measurement results from the receiver
  input wire logic measure_valid,
  input wire logic [7:0] input_power_value,
  input wire logic [7:0] link_quality_value,
  // Slow oscillator and wake timer
  input wire logic slow_osc_tick,
  output logic wake_prescaled_tick,
  output logic [2:0] wake_divider_code,
  output logic [3:0] sleep_retention_code,
  output logic sleep_keep_backup_ram,
  output logic sleep_keep_crystal_osc,
  output logic sleep_keep_rc_osc,
  output logic wake_on_timeout,
  output logic [15:0] wake_reload_value,
  // Radio configuration
  output logic [23:0] channel_frequency_word,
  output logic preemphasis_enable,
  output logic [7:0] packet_format_select,
  output logic packet_mode,
  output logic rx_serial_port_mode,
  output logic tx_serial_port_mode,
  output logic [7:0] transmit_buffer_base,
  output logic [7:0] receive_buffer_base,
  output logic [3:0] program_ram_page
);

  start_delay_if dly ();

  logic [7:0] rx_delay, next_rx_delay;
  logic [7:0] tx_delay, next_tx_delay;
  logic [7:0] delay_ext, next_delay_ext;
  logic [7:0] next_format;
  logic next_packet_mode, next_rx_serial, next_tx_serial;
  logic [23:0] next_channel;
  logic [7:0] tx_mod, next_tx_mod;
  logic [7:0] power_result, next_power_result;
  logic [7:0] quality_result, next_quality_result;
  logic [3:0] next_page;
  logic [7:0] next_tx_base, next_rx_base;
  logic [2:0] staged_div, next_staged_div;
  logic [2:0] next_div_code;
  logic [7:0] sleep_reg, next_sleep_reg;
  logic next_keep_ram, next_keep_xtal, next_keep_rc;
  logic [7:0] staged_reload_high, next_staged_reload_high;
  logic [15:0] next_reload;
  logic [15:0] div_count, next_div_count;
  logic next_prescaled_tick;
  logic [7:0] next_rdata;
  logic wr_sleep;

  // Address match used by the write decoder; the read decoder uses a case on the address
  function automatic logic hit(input logic [9:0] addr, input logic [9:0] offset);
    hit = (addr == offset);
  endfunction

  // Final count of the slow clock divider for each code
  function automatic logic [15:0] div_last(input logic [2:0] code);
    unique case (code)
      3'h0: div_last = radio_cfg_pkg::DIV_LAST_0;
      3'h1: div_last = radio_cfg_pkg::DIV_LAST_1;
      3'h2: div_last = radio_cfg_pkg::DIV_LAST_2;
      3'h3: div_last = radio_cfg_pkg::DIV_LAST_3;
      3'h4: div_last = radio_cfg_pkg::DIV_LAST_4;
      3'h5: div_last = radio_cfg_pkg::DIV_LAST_5;
      3'h6: div_last = radio_cfg_pkg::DIV_LAST_6;
      3'h7: div_last = radio_cfg_pkg::DIV_LAST_7;
    endcase
  endfunction

  assign wr_sleep = reg_wr && hit(reg_addr, radio_cfg_pkg::WAKE_SLEEP_OFFSET);

  // Writable configuration and decoded flags
  always_comb begin
    next_rx_delay = rx_delay;
    next_tx_delay = tx_delay;
    next_delay_ext = delay_ext;
    next_format = packet_format_select;
    next_channel = channel_frequency_word;
    next_tx_mod = tx_mod;
    next_page = program_ram_page;
    next_tx_base = transmit_buffer_base;
    next_rx_base = receive_buffer_base;
    next_staged_div = staged_div;
    next_div_code = wake_divider_code;
    next_sleep_reg = sleep_reg;
    next_staged_reload_high = staged_reload_high;
    next_reload = wake_reload_value;
    if (reg_wr) begin
      if (hit(reg_addr, radio_cfg_pkg::RX_DELAY_OFFSET)) next_rx_delay = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::TX_DELAY_OFFSET)) next_tx_delay = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::DELAY_EXT_OFFSET)) next_delay_ext = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::PKT_FORMAT_OFFSET)) next_format = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::CHAN_LOW_OFFSET)) next_channel[7:0] = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::CHAN_MID_OFFSET)) next_channel[15:8] = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::CHAN_HIGH_OFFSET)) next_channel[23:16] = reg_wdata;
      // Upper bits kept as written; the radio controller owns their meaning
      if (hit(reg_addr, radio_cfg_pkg::TX_MOD_OFFSET)) next_tx_mod = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::PRAM_PAGE_OFFSET)) begin
        next_page = reg_wdata[radio_cfg_pkg::PRAM_PAGE_MSB:0];
      end
      if (hit(reg_addr, radio_cfg_pkg::TX_BASE_OFFSET)) next_tx_base = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::RX_BASE_OFFSET)) next_rx_base = reg_wdata;
      if (hit(reg_addr, radio_cfg_pkg::WAKE_DIV_OFFSET)) begin
        next_staged_div = reg_wdata[radio_cfg_pkg::WAKE_DIV_MSB:0];
      end
      if (hit(reg_addr, radio_cfg_pkg::RELOAD_HIGH_OFFSET)) begin
        next_staged_reload_high = reg_wdata;
      end
      if (hit(reg_addr, radio_cfg_pkg::RELOAD_LOW_OFFSET)) begin
        next_reload = {staged_reload_high, reg_wdata};
      end
    end
    // A divider written in the same cycle as sleep config is not yet staged
    if (wr_sleep) begin
      next_sleep_reg = reg_wdata;
      next_div_code = staged_div;
    end
    next_packet_mode = (next_format == radio_cfg_pkg::FORMAT_PACKET);
    next_rx_serial = (next_format == radio_cfg_pkg::FORMAT_RX_SERIAL);
    next_tx_serial = (next_format == radio_cfg_pkg::FORMAT_TX_SERIAL);
    unique case (next_sleep_reg[radio_cfg_pkg::SLEEP_CODE_MSB:radio_cfg_pkg::SLEEP_CODE_LSB])
      radio_cfg_pkg::SLEEP_KEEP_BACKUP_RAM: begin
        {next_keep_ram, next_keep_xtal, next_keep_rc} = 3'b100;
      end
      radio_cfg_pkg::SLEEP_KEEP_CRYSTAL_OSC: begin
        {next_keep_ram, next_keep_xtal, next_keep_rc} = 3'b010;
      end
      radio_cfg_pkg::SLEEP_KEEP_RAM_AND_CRYSTAL: begin
        {next_keep_ram, next_keep_xtal, next_keep_rc} = 3'b110;
      end
      radio_cfg_pkg::SLEEP_KEEP_RAM_AND_RC_OSC: begin
        {next_keep_ram, next_keep_xtal, next_keep_rc} = 3'b101;
      end
      // Reserved codes keep nothing alive
      default: {next_keep_ram, next_keep_xtal, next_keep_rc} = 3'b000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_delay <= radio_cfg_pkg::RX_DELAY_RESET;
      tx_delay <= radio_cfg_pkg::TX_DELAY_RESET;
      delay_ext <= radio_cfg_pkg::DELAY_EXT_RESET;
      packet_format_select <= radio_cfg_pkg::PKT_FORMAT_RESET;
      packet_mode <= 1'b1;
      rx_serial_port_mode <= 1'b0;
      tx_serial_port_mode <= 1'b0;
      channel_frequency_word <= {radio_cfg_pkg::CHAN_HIGH_RESET,
        radio_cfg_pkg::CHAN_MID_RESET, radio_cfg_pkg::CHAN_LOW_RESET};
      tx_mod <= radio_cfg_pkg::TX_MOD_RESET;
      preemphasis_enable <= radio_cfg_pkg::TX_MOD_RESET[radio_cfg_pkg::PREEMP_BIT];
      program_ram_page <= radio_cfg_pkg::PRAM_PAGE_RESET;
      transmit_buffer_base <= radio_cfg_pkg::TX_BASE_RESET;
      receive_buffer_base <= radio_cfg_pkg::RX_BASE_RESET;
      staged_div <= radio_cfg_pkg::WAKE_DIV_RESET;
      wake_divider_code <= radio_cfg_pkg::WAKE_DIV_RESET;
      sleep_reg <= 8'h00;
      sleep_retention_code <= radio_cfg_pkg::SLEEP_CODE_RESET;
      sleep_keep_backup_ram <= 1'b0;
      sleep_keep_crystal_osc <= 1'b0;
      sleep_keep_rc_osc <= 1'b0;
      wake_on_timeout <= 1'b0;
      staged_reload_high <= 8'h00;
      wake_reload_value <= radio_cfg_pkg::RELOAD_RESET;
    end else begin
      rx_delay <= next_rx_delay;
      tx_delay <= next_tx_delay;
      delay_ext <= next_delay_ext;
      packet_format_select <= next_format;
      packet_mode <= next_packet_mode;
      rx_serial_port_mode <= next_rx_serial;
      tx_serial_port_mode <= next_tx_serial;
      channel_frequency_word <= next_channel;
      tx_mod <= next_tx_mod;
      preemphasis_enable <= next_tx_mod[radio_cfg_pkg::PREEMP_BIT];
      program_ram_page <= next_page;
      transmit_buffer_base <= next_tx_base;
      receive_buffer_base <= next_rx_base;
      staged_div <= next_staged_div;
      wake_divider_code <= next_div_code;
      sleep_reg <= next_sleep_reg;
      sleep_retention_code <=
        next_sleep_reg[radio_cfg_pkg::SLEEP_CODE_MSB:radio_cfg_pkg::SLEEP_CODE_LSB];
      sleep_keep_backup_ram <= next_keep_ram;
      sleep_keep_crystal_osc <= next_keep_xtal;
      sleep_keep_rc_osc <= next_keep_rc;
      wake_on_timeout <= next_sleep_reg[radio_cfg_pkg::WAKE_ON_TIMEOUT_BIT];
      staged_reload_high <= next_staged_reload_high;
      wake_reload_value <= next_reload;
    end
  end

  // Readbacks follow the receiver's measurement strobe
  always_comb begin
    next_power_result = power_result;
    next_quality_result = quality_result;
    if (measure_valid) begin
      next_power_result = input_power_value;
      next_quality_result = link_quality_value;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_result <= radio_cfg_pkg::READBACK_RESET;
      quality_result <= radio_cfg_pkg::READBACK_RESET;
    end else begin
      power_result <= next_power_result;
      quality_result <= next_quality_result;
    end
  end

  // Slow clock prescaler; restarts whenever a new divider is applied
  always_comb begin
    next_div_count = div_count;
    next_prescaled_tick = 1'b0;
    if (wr_sleep) begin
      next_div_count = 16'h0000;
    end else if (slow_osc_tick) begin
      if (div_count >= div_last(wake_divider_code)) begin
        next_div_count = 16'h0000;
        next_prescaled_tick = 1'b1;
      end else begin
        next_div_count = div_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_count <= 16'h0000;
      wake_prescaled_tick <= 1'b0;
    end else begin
      div_count <= next_div_count;
      wake_prescaled_tick <= next_prescaled_tick;
    end
  end

  // Read data; write-only and unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      radio_cfg_pkg::RX_DELAY_OFFSET: next_rdata = rx_delay;
      radio_cfg_pkg::TX_DELAY_OFFSET: next_rdata = tx_delay;
      radio_cfg_pkg::DELAY_EXT_OFFSET: next_rdata = delay_ext;
      radio_cfg_pkg::PKT_FORMAT_OFFSET: next_rdata = packet_format_select;
      radio_cfg_pkg::CHAN_LOW_OFFSET: next_rdata = channel_frequency_word[7:0];
      radio_cfg_pkg::CHAN_MID_OFFSET: next_rdata = channel_frequency_word[15:8];
      radio_cfg_pkg::CHAN_HIGH_OFFSET: next_rdata = channel_frequency_word[23:16];
      radio_cfg_pkg::TX_MOD_OFFSET: next_rdata = tx_mod;
      radio_cfg_pkg::POWER_OFFSET: next_rdata = power_result;
      radio_cfg_pkg::QUALITY_OFFSET: next_rdata = quality_result;
      radio_cfg_pkg::PRAM_PAGE_OFFSET: next_rdata = {4'h0, program_ram_page};
      radio_cfg_pkg::TX_BASE_OFFSET: next_rdata = transmit_buffer_base;
      radio_cfg_pkg::RX_BASE_OFFSET: next_rdata = receive_buffer_base;
      radio_cfg_pkg::WAKE_SLEEP_OFFSET: next_rdata = sleep_reg;
      radio_cfg_pkg::RELOAD_LOW_OFFSET: next_rdata = wake_reload_value[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // Start delay sequencing
  assign dly.start_tx = transmit_command;
  assign dly.start_rx = receive_command;
  assign dly.tx_base_us = tx_delay;
  assign dly.rx_base_us = rx_delay;
  assign dly.ext_steps = delay_ext;

  start_delay_timer delay_timer (
    .clk(clk),
    .rst(rst),
    .dly(dly.timer)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_state_enter <= 1'b0;
      receive_search_start <= 1'b0;
      start_delay_busy <= 1'b0;
    end else begin
      transmit_state_enter <= dly.done_tx;
      receive_search_start <= dly.done_rx;
      start_delay_busy <= dly.busy;
    end
  end

endmodule

/* core/start_delay_if.sv */
`timescale 1ns/100ps
interface start_delay_if;
  logic start_tx;
  logic start_rx;
  logic [7:0] tx_base_us;
  logic [7:0] rx_base_us;
  logic [7:0] ext_steps;
  logic done_tx;
  logic done_rx;
  logic busy;

  modport requester (
    output start_tx, start_rx, tx_base_us, rx_base_us, ext_steps,
    input done_tx, done_rx, busy
  );
  modport timer (
    input start_tx, start_rx, tx_base_us, rx_base_us, ext_steps,
    output done_tx, done_rx, busy
  );
endinterface

/* core/start_delay_timer.sv */
`timescale 1ns/100ps
module start_delay_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Delay requests
  start_delay_if.timer dly
);

  radio_cfg_pkg::seq_state_t state, next_state;
  logic [4:0] us_div, next_us_div;
  logic [10:0] us_left, next_us_left;
  logic next_done_tx, next_done_rx, next_busy;

  // Base in 1 us steps plus extension in 4 us steps
  function automatic logic [10:0] total_us(input logic [7:0] base, input logic [7:0] ext);
    total_us = {3'h0, base} + ({3'h0, ext} << radio_cfg_pkg::EXT_SHIFT);
  endfunction

  // Sequencer; the microsecond divider restarts with each command so steps are exact
  always_comb begin
    next_state = state;
    next_us_div = us_div;
    next_us_left = us_left;
    next_done_tx = 1'b0;
    next_done_rx = 1'b0;
    unique case (state)
      radio_cfg_pkg::SEQ_IDLE: begin
        next_us_div = 5'h00;
        if (dly.start_tx) begin
          next_state = radio_cfg_pkg::SEQ_TX_WAIT;
          next_us_left = total_us(dly.tx_base_us, dly.ext_steps);
        end else if (dly.start_rx) begin
          next_state = radio_cfg_pkg::SEQ_RX_WAIT;
          next_us_left = total_us(dly.rx_base_us, dly.ext_steps);
        end
      end
      radio_cfg_pkg::SEQ_TX_WAIT, radio_cfg_pkg::SEQ_RX_WAIT: begin
        if (us_left == 11'h000) begin
          next_state = radio_cfg_pkg::SEQ_IDLE;
          next_done_tx = (state == radio_cfg_pkg::SEQ_TX_WAIT);
          next_done_rx = (state == radio_cfg_pkg::SEQ_RX_WAIT);
        end else if (us_div == radio_cfg_pkg::US_LAST) begin
          next_us_div = 5'h00;
          next_us_left = us_left - 11'h001;
          if (us_left == 11'h001) begin
            next_state = radio_cfg_pkg::SEQ_IDLE;
            next_done_tx = (state == radio_cfg_pkg::SEQ_TX_WAIT);
            next_done_rx = (state == radio_cfg_pkg::SEQ_RX_WAIT);
          end
        end else begin
          next_us_div = us_div + 5'h01;
        end
      end
      default: next_state = radio_cfg_pkg::SEQ_IDLE;
    endcase
    next_busy = (next_state != radio_cfg_pkg::SEQ_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= radio_cfg_pkg::SEQ_IDLE;
      us_div <= 5'h00;
      us_left <= 11'h000;
      dly.done_tx <= 1'b0;
      dly.done_rx <= 1'b0;
      dly.busy <= 1'b0;
    end else begin
      state <= next_state;
      us_div <= next_us_div;
      us_left <= next_us_left;
      dly.done_tx <= next_done_tx;
      dly.done_rx <= next_done_rx;
      dly.busy <= next_busy;
    end
  end

endmodule

/* tb/radio_config_register_bank_assertions.sv */
`timescale 1ns/100ps
module radio_config_register_bank_assertions (
  // Clock, reset and register writes
  input wire logic clk, rst, reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Watched outputs
  input wire logic transmit_state_enter, preemphasis_enable, packet_mode, tx_serial_port_mode,
  input wire logic sleep_keep_backup_ram, sleep_keep_crystal_osc, sleep_keep_rc_osc,
  input wire logic [2:0] wake_divider_code,
  input wire logic [3:0] sleep_retention_code,
  input wire logic [15:0] wake_reload_value,
  input wire logic [23:0] channel_frequency_word,
  input wire logic [7:0] packet_format_select, transmit_buffer_base
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Writes show one cycle after the taking edge
  chan_low_wr_a: assert property (
    reg_wr && reg_addr == 10'h300 |=> channel_frequency_word[7:0] == $past(reg_wdata))
    else $error("channel low byte not written");
  tx_base_wr_a: assert property (
    reg_wr && reg_addr == 10'h314 |=> transmit_buffer_base == $past(reg_wdata))
    else $error("transmit base not written");
  preemp_set_a: assert property (
    reg_wr && reg_addr == 10'h306 && reg_wdata[0] |=> preemphasis_enable)
    else $error("preemphasis not enabled");
  mode_decode_a: assert property (
    packet_mode == (packet_format_select == 8'h00) &&
    tx_serial_port_mode == (packet_format_select == 8'h03))
    else $error("format decode wrong");
  // Staged values move only on their trigger writes
  reload_hold_a: assert property (
    !(reg_wr && reg_addr == 10'h319) |=> $stable(wake_reload_value))
    else $error("reload changed without low byte write");
  divider_hold_a: assert property (
    !(reg_wr && reg_addr == 10'h317) |=> $stable(wake_divider_code))
    else $error("divider changed without sleep write");
  sleep_decode_a: assert property (
    sleep_retention_code == 4'hB |->
    sleep_keep_backup_ram && !sleep_keep_crystal_osc && sleep_keep_rc_osc)
    else $error("retention decode wrong");
  enter_pulse_a: assert property (
    transmit_state_enter |=> !transmit_state_enter)
    else $error("transmit enter longer than one cycle");
endmodule

/* tb/test_radio_config_register_bank.sv */
`timescale 1ns/100ps
module test_radio_config_register_bank;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, transmit_command = 0, receive_command = 0;
  logic measure_valid = 0, slow_osc_tick = 0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, input_power_value = 8'h00, link_quality_value = 8'h00;
  logic reg_rvalid, transmit_state_enter, receive_search_start, start_delay_busy;
  logic wake_prescaled_tick, wake_on_timeout, preemphasis_enable;
  logic packet_mode, rx_serial_port_mode, tx_serial_port_mode;
  logic sleep_keep_backup_ram, sleep_keep_crystal_osc, sleep_keep_rc_osc;
  logic [2:0] wake_divider_code;
  logic [3:0] sleep_retention_code, program_ram_page;
  logic [15:0] wake_reload_value;
  logic [23:0] channel_frequency_word;
  logic [7:0] reg_rdata, packet_format_select, transmit_buffer_base, receive_buffer_base;
  int bad_count = 0, samples_checked = 0, cycles = 0;

  radio_config_register_bank u_dut (.*);

  always #25 clk = ~clk;
  // Hang guard, well above the longest test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      give_verdict;
    end
  end

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Bus tasks leave an idle cycle so a strobe is never reassigned in one step
  task automatic wr(logic [9:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    #50 reg_wr = 0;
    #50;
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    #50 reg_rd = 0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", e, reg_rdata);
    #50;
  endtask

  task automatic t_reset;
    logic [9:0] a[16] = '{10'h10A, 10'h10B, 10'h13E, 10'h300, 10'h301, 10'h302, 10'h306,
      10'h30C, 10'h30D, 10'h313, 10'h314, 10'h315, 10'h316, 10'h317, 10'h319, 10'h200};
    logic [7:0] e[16] = '{8'hC0, 8'h00, 8'h00, 8'h80, 8'hA9, 8'h03, 8'h01,
      8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    foreach (a[i]) rd(a[i], e[i]);
    $display("test reset values done");
  endtask

  task automatic t_modes;
    logic [7:0] c[4] = '{8'h02, 8'h03, 8'h01, 8'h00};
    logic [7:0] f[4] = '{8'h02, 8'h01, 8'h00, 8'h04};
    foreach (c[i]) begin
      wr(10'h13E, c[i]);
      chk("mode", f[i], {5'h00, packet_mode, rx_serial_port_mode, tx_serial_port_mode});
    end
    $display("test format modes done");
  endtask

  task automatic t_config;
    wr(10'h300, 8'h12);
    wr(10'h301, 8'h34);
    wr(10'h302, 8'h56);
    chk("word", 8'h56, channel_frequency_word[23:16]);
    chk("word", 8'h12, channel_frequency_word[7:0]);
    chk("word", 8'h34, channel_frequency_word[15:8]);
    wr(10'h314, 8'h5A);
    wr(10'h315, 8'hA5);
    rd(10'h314, 8'h5A);
    rd(10'h315, 8'hA5);
    chk("rx base", 8'hA5, receive_buffer_base);
    // Page field only; the reserved upper nibble goes back as zero
    wr(10'h313, 8'h0C);
    chk("page", 8'h0C, {4'h0, program_ram_page});
    rd(10'h313, 8'h0C);
    // Controller bits stay at their reset zeros; only preemphasis toggles
    wr(10'h306, 8'h00);
    chk("preemph", 8'h00, {7'h00, preemphasis_enable});
    rd(10'h306, 8'h00);
    wr(10'h306, 8'h01);
    chk("preemph", 8'h01, {7'h00, preemphasis_enable});
    wr(10'h30C, 8'h77);
    rd(10'h30C, 8'h00);
    measure_valid = 1;
    input_power_value = 8'hF6;
    link_quality_value = 8'h3C;
    #50 measure_valid = 0;
    rd(10'h30C, 8'hF6);
    rd(10'h30D, 8'h3C);
    $display("test config and readback done");
  endtask

  task automatic t_wake;
    logic [7:0] n = 8'h00;
    wr(10'h316, 8'h01);
    chk("divider", 8'h00, {5'h00, wake_divider_code});
    wr(10'h317, 8'h59);
    chk("divider", 8'h01, {5'h00, wake_divider_code});
    chk("sleep", 8'hBB, {sleep_keep_backup_ram, sleep_keep_crystal_osc, sleep_keep_rc_osc,
      wake_on_timeout, sleep_retention_code});
    // Divide by four: eight slow ticks give two prescaled ticks
    repeat (8) begin
      slow_osc_tick = 1;
      #50 slow_osc_tick = 0;
      n += {7'h00, wake_prescaled_tick};
      #50 n += {7'h00, wake_prescaled_tick};
    end
    chk("prescale", 8'h02, n);
    wr(10'h318, 8'hAB);
    chk("reload", 8'h00, wake_reload_value[15:8]);
    wr(10'h319, 8'hCD);
    chk("reload", 8'hAB, wake_reload_value[15:8]);
    rd(10'h319, 8'hCD);
    $display("test wake timer done");
  endtask

  // Cycles from the command edge to the start pulse: N*20+1
  task automatic t_delay(bit tx, logic [7:0] e);
    logic [7:0] n = 8'h00;
    transmit_command = tx;
    receive_command = !tx;
    #50 transmit_command = 0;
    receive_command = 0;
    // Busy shows two edges after the command, well before any pulse
    #50 n = 8'h01;
    chk("busy", 8'h01, {7'h00, start_delay_busy});
    while (n < 8'hC8 && (tx ? transmit_state_enter : receive_search_start) !== 1'b1) begin
      #50 n++;
    end
    chk("delay", e, n);
    #50;
    $display("test start delay done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #5 rst = 0;
    t_reset;
    t_modes;
    t_config;
    t_wake;
    wr(10'h10A, 8'h01);
    wr(10'h10B, 8'h01);
    wr(10'h109, 8'h00);
    t_delay(1'b1, 8'h65);
    t_delay(1'b0, 8'h51);
    give_verdict;
  end
endmodule

bind radio_config_register_bank radio_config_register_bank_assertions u_chk (.*);
